//--- dou_consts.vh
`ifndef DOU_CONSTS_VH
`define DOU_CONSTS_VH

// Channel count and code width
`define DOU_NCH 8
`define DOU_DW 14
`define DOU_CHW 3

// Reset codes of the data registers and latches
`define DOU_CODE_ZERO 14'h0000
`define DOU_CODE_MID 14'h2000

// Offset register defaults per code format
`define DOU_OFS_USB 14'h2666
`define DOU_OFS_BTC 14'h0666

// Input data register reset value
`define DOU_INDATA_RST 14'h0000

// General-purpose pins
`define DOU_GPIO_N 3
`define DOU_GPIO_RST 3'h7

// Cycles after reset release before the straps are taken (covers the synchroniser)
`define DOU_INIT_CYC 2'h3

// Reset value of the pin synchroniser: strobes and selects idle high
`define DOU_PIN_RST 7'h7f

`endif

//--- dou_sync.v
`timescale 1ns/10ps
`include "dou_consts.vh"

module dou_sync #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);

	reg [W-1:0] meta;

	// Two-stage synchroniser; the first stage feeds only the second
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

//--- dou_chan.v
`timescale 1ns/10ps
`include "dou_consts.vh"

module dou_chan (
	input  wire                clk,
	input  wire                rst_n,
	input  wire                preset,
	input  wire [`DOU_DW-1:0]  preset_code,
	input  wire                wr,
	input  wire [`DOU_DW-1:0]  wr_data,
	input  wire                direct,
	input  wire                load,
	output reg  [`DOU_DW-1:0]  dreg,
	output reg  [`DOU_DW-1:0]  latch,
	output reg                 accessed
);

	// One channel: data register, latch and access flag
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dreg     <= `DOU_CODE_ZERO;
			latch    <= `DOU_CODE_ZERO;
			accessed <= 1'b0;
		end else if (preset) begin
			dreg     <= preset_code;                  // [RULE8] [RULE11]
			latch    <= preset_code;                  // [RULE8] [RULE11]
			accessed <= 1'b0;
		end else begin
			if (wr) begin
				dreg <= wr_data;
			end
			// Direct write bypasses the access flag; otherwise only accessed latches reload
			if (wr && direct) begin
				latch <= wr_data;                     // [RULE17] [RULE18]
			end else if (load && accessed) begin
				latch <= dreg;                        // [RULE16]
			end
			// A write in the load cycle keeps the flag set for the next load
			accessed <= (wr & ~direct) | (accessed & ~load); // [RULE23]
		end
	end

endmodule

//--- dou_ctrl.v
// Summary of operation
// RULE1 - Output-mode GPIO floats when its bit is 1, drives low when 0.
// RULE2 - Reading a GPIO bit returns the level now on that pin.
// RULE3 - Every reset sets all GPIO bits to 1 so the pins float.
// RULE4 - Clear low grounds all outputs and puts output buffers in high impedance.
// RULE5 - Strobes ignored during clear; released with strobe high, stay cleared until strobe low.
// RULE6 - With strobe held low, outputs return to latch values when clear rises.
// RULE7 - Clear leaves zero, gain, input, data registers and latches untouched.
// RULE8 - Power-on loads offset, data, latches from reset level; input data cleared.
// RULE9 - Dual supply reset codes depend on level and format; offset 2666h or 0666h.
// RULE10 - Single supply disables offset converter, same reset data codes.
// RULE11 - Hardware reset holds registers and latches at reset values, input data cleared.
// RULE12 - During hardware reset serial port disabled, select ignored, serial output floats.
// RULE13 - After reset outputs keep reset values; serial port resumes.
// RULE14 - Host keeps chip select high while driving hardware reset.
// RULE15 - Update mode taken at power-on from strobe level: low async, high sync.
// RULE16 - Load refreshes only latches written since last load; others keep contents.
// RULE17 - Async mode ignores strobe and load bit; engine off updates at select rise.
// RULE18 - Async mode with engine on updates each latch when engine writes it.
// RULE19 - Sync mode, engine off: strobe low or load bit updates accessed latches together.
// RULE20 - Sync mode, engine on: load waits until engine finished its data writes.
// RULE21 - Sync mode without strobe low or load bit leaves latches unchanged.
// RULE22 - Host keeps strobe high before select falls and waits after select rises.
// RULE23 - One access flag per channel, set by write, cleared on latch refresh.
`timescale 1ns/10ps
`include "dou_consts.vh"

module dou_ctrl (
	input  wire                          core_clk,
	input  wire                          resetn,
	input  wire                          hw_reset_n,
	input  wire                          soft_reset,
	input  wire                          chip_select_n,
	input  wire                          output_clear_n,
	input  wire                          latch_load_strobe_n,
	input  wire                          reset_level_select,
	input  wire                          code_format_select,
	input  wire                          single_supply,
	input  wire                          host_wr_valid,
	input  wire [`DOU_CHW-1:0]           host_wr_chan,
	input  wire [`DOU_DW-1:0]            host_wr_data,
	input  wire                          latch_load_bit,
	input  wire                          correction_engine_on,
	input  wire                          eng_wr_valid,
	input  wire [`DOU_CHW-1:0]           eng_wr_chan,
	input  wire [`DOU_DW-1:0]            eng_wr_data,
	input  wire                          eng_busy,
	input  wire                          sdo_drive,
	input  wire                          gpio_wr,
	input  wire [`DOU_GPIO_N-1:0]        gpio_wr_data,
	input  wire [`DOU_GPIO_N-1:0]        gpio_in,
	output wire [`DOU_GPIO_N-1:0]        gpio_out,
	output wire [`DOU_GPIO_N-1:0]        gpio_oe_n,
	output reg  [`DOU_GPIO_N-1:0]        gpio_rd_data,
	output reg                           eng_req,
	output reg  [`DOU_CHW-1:0]           eng_req_chan,
	output reg  [`DOU_DW-1:0]            input_data,
	output wire [`DOU_NCH*`DOU_DW-1:0]   chan_latch,
	output wire [`DOU_NCH*`DOU_DW-1:0]   chan_data,
	output wire [`DOU_NCH-1:0]           access_flags,
	output reg                           outputs_cleared,
	output reg  [`DOU_DW-1:0]            offset_code,
	output reg                           offset_dac_on,
	output reg                           cal_defaults_load,
	output reg                           serial_enable,
	output wire                          sdo_oe_n,
	output reg                           sync_mode,
	output wire                          mode_valid
);

	reg  [1:0]                rst_pipe;
	wire                      rst_n;
	wire [6:0]                pin_s;
	wire [`DOU_GPIO_N-1:0]    gpio_s;
	wire                      hwrst_s;
	wire                      cs_s;
	wire                      clr_s;
	wire                      latch_load_strobe_n_s;
	wire                      rsel_s;
	wire                      fmt_s;
	wire                      single_s;
	reg                       cs_q;
	reg                       latch_load_strobe_n_q;
	reg  [1:0]                init_cnt;
	wire                      init_busy;
	wire                      rst_active;
	wire [`DOU_DW-1:0]        preset_code;
	reg                       pend_v;
	reg  [`DOU_CHW-1:0]       pend_ch;
	wire                      cs_rise;
	wire                      commit;
	wire                      latch_load_strobe_n_fall;
	wire                      ld_event;
	wire                      eng_idle;
	wire                      ld_fire;
	reg                       ld_pend;
	reg                       clear_hold;
	reg  [`DOU_GPIO_N-1:0]    gpio_bits;
	reg  [`DOU_NCH-1:0]       ch_wr;
	reg  [`DOU_DW-1:0]        ch_wr_data;

	// Reset release through two flip-flops; rest of the block uses rst_n
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	// Pins from outside the clock domain, each through two flip-flops
	dou_sync #(
		.W       (7),
		.RST_VAL (`DOU_PIN_RST)
	) u_pin_sync (
		.clk   (core_clk),
		.rst_n (rst_n),
		.d     ({hw_reset_n, chip_select_n, output_clear_n, latch_load_strobe_n,
		         reset_level_select, code_format_select, single_supply}),
		.q     (pin_s)
	);

	dou_sync #(
		.W       (`DOU_GPIO_N),
		.RST_VAL (`DOU_GPIO_RST)
	) u_gpio_sync (
		.clk   (core_clk),
		.rst_n (rst_n),
		.d     (gpio_in),
		.q     (gpio_s)
	);

	assign hwrst_s  = pin_s[6];
	assign cs_s     = pin_s[5];
	assign clr_s    = pin_s[4];
	assign latch_load_strobe_n_s   = pin_s[3];
	assign rsel_s   = pin_s[2];
	assign fmt_s    = pin_s[1];
	assign single_s = pin_s[0];

	// Edge history of select and strobe
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_q   <= 1'b1;
			latch_load_strobe_n_q <= 1'b1;
		end else begin
			cs_q   <= cs_s;
			latch_load_strobe_n_q <= latch_load_strobe_n_s;
		end
	end

	// Power-on phase: wait until the synchronised straps are valid, then take the mode.
	// The mode is never taken again, so later strobe activity cannot change it.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt  <= 2'h0;
			sync_mode <= 1'b0;
		end else if (init_busy) begin
			init_cnt <= init_cnt + 2'h1;
			if (init_cnt == (`DOU_INIT_CYC - 2'h1)) begin
				sync_mode <= latch_load_strobe_n_s;                  // [RULE15]
			end
		end
	end
	assign init_busy  = (init_cnt != `DOU_INIT_CYC);
	assign mode_valid = ~init_busy;

	// Power-on phase, hardware reset pin and software reset all hold the block in reset
	assign rst_active = init_busy | ~hwrst_s | soft_reset; // [RULE8] [RULE11]

	// Reset data code: midscale code when level and format selects differ
	assign preset_code = (rsel_s ^ fmt_s) ? `DOU_CODE_MID : `DOU_CODE_ZERO; // [RULE9] [RULE10]

	// Offset register default, gain/zero default load, offset converter enable
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			offset_code       <= `DOU_OFS_USB;
			offset_dac_on     <= 1'b0;
			cal_defaults_load <= 1'b1;
		end else begin
			if (rst_active) begin
				offset_code <= fmt_s ? `DOU_OFS_BTC : `DOU_OFS_USB; // [RULE9]
			end
			offset_dac_on     <= ~single_s;           // [RULE10]
			cal_defaults_load <= rst_active;          // [RULE8] [RULE11]
		end
	end

	// Serial port is shut while in reset; SDO floats. Resumes on release.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_enable <= 1'b0;
		end else begin
			serial_enable <= ~rst_active;             // [RULE12] [RULE13]
		end
	end
	assign sdo_oe_n = ~(serial_enable & sdo_drive);   // [RULE12]

	// Select rise commits the staged word; ignored in reset since the host keeps
	// select high then, any edge seen is spurious [RULE14]
	assign cs_rise = cs_s & ~cs_q & ~rst_active;     // [RULE12]
	assign commit  = cs_rise & pend_v;

	// Input data register stages the host word until select rises
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_v     <= 1'b0;
			pend_ch    <= {`DOU_CHW{1'b0}};
			input_data <= `DOU_INDATA_RST;
		end else if (rst_active) begin
			pend_v     <= 1'b0;
			input_data <= `DOU_INDATA_RST;            // [RULE8] [RULE11]
		end else if (host_wr_valid && serial_enable) begin
			pend_v     <= 1'b1;
			pend_ch    <= host_wr_chan;
			input_data <= host_wr_data;
		end else if (commit) begin
			pend_v <= 1'b0;
		end
	end

	// With the engine on, a committed word is handed to it instead of written direct
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			eng_req      <= 1'b0;
			eng_req_chan <= {`DOU_CHW{1'b0}};
		end else begin
			eng_req <= commit & correction_engine_on;
			if (commit) begin
				eng_req_chan <= pend_ch;
			end
		end
	end

	// Channel write select: host word with engine off, engine write with engine on
	always @* begin
		ch_wr      = {`DOU_NCH{1'b0}};
		ch_wr_data = input_data;
		if (!rst_active) begin
			if (commit && !correction_engine_on) begin
				ch_wr[pend_ch] = 1'b1;                // [RULE17]
			end else if (eng_wr_valid && correction_engine_on) begin
				ch_wr[eng_wr_chan] = 1'b1;            // [RULE18]
				ch_wr_data         = eng_wr_data;
			end
		end
	end

	// Load request in sync mode; strobe edges ignored while clear is low.
	// Async mode ignores both the strobe and the load bit.
	assign latch_load_strobe_n_fall = latch_load_strobe_n_q & ~latch_load_strobe_n_s;
	assign ld_event  = sync_mode & ~rst_active &
	                   ((latch_load_strobe_n_fall & clr_s) | latch_load_bit); // [RULE5] [RULE17] [RULE19]

	// Engine must be quiet, with nothing still pending for it, before latches load
	assign eng_idle = ~correction_engine_on |
	                  (~eng_busy & ~eng_req & ~eng_wr_valid & ~pend_v); // [RULE20]
	assign ld_fire  = (ld_pend | ld_event) & eng_idle;   // [RULE19] [RULE21]

	// Deferred load held until the engine drains
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ld_pend <= 1'b0;
		end else if (rst_active) begin
			ld_pend <= 1'b0;
		end else begin
			ld_pend <= (ld_pend | ld_event) & ~ld_fire; // [RULE20]
		end
	end

	// Clear holds until clear is high and the strobe is low; with the strobe tied low
	// this releases at once. Only the output stage is touched, registers keep data.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clear_hold <= 1'b0;
		end else begin
			clear_hold <= ~clr_s | (clear_hold & latch_load_strobe_n_s); // [RULE4] [RULE5] [RULE6] [RULE7]
		end
	end

	// Outputs grounded with buffers off while held cleared
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			outputs_cleared <= 1'b0;
		end else begin
			outputs_cleared <= clear_hold & ~clr_s | clear_hold; // [RULE4]
		end
	end

	// Channel slots; async mode writes the latch together with the data register
	genvar gi;
	generate
		for (gi = 0; gi < `DOU_NCH; gi = gi + 1) begin : g_ch
			dou_chan u_ch (
				.clk         (core_clk),
				.rst_n       (rst_n),
				.preset      (rst_active),
				.preset_code (preset_code),
				.wr          (ch_wr[gi]),
				.wr_data     (ch_wr_data),
				.direct      (~sync_mode),
				.load        (ld_fire),
				.dreg        (chan_data[gi*`DOU_DW +: `DOU_DW]),
				.latch       (chan_latch[gi*`DOU_DW +: `DOU_DW]),
				.accessed    (access_flags[gi])
			);
		end
	endgenerate

	// GPIO bits: every reset floats the pins, software writes otherwise
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gpio_bits <= `DOU_GPIO_RST;
		end else if (rst_active) begin
			gpio_bits <= `DOU_GPIO_RST;               // [RULE3]
		end else if (gpio_wr && serial_enable) begin
			gpio_bits <= gpio_wr_data;
		end
	end

	// Open drain: data always low, enable active low only where the bit is 0
	assign gpio_out  = {`DOU_GPIO_N{1'b0}};
	assign gpio_oe_n = gpio_bits;                     // [RULE1]

	// Read-back shows the pin level itself, not the stored bit
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gpio_rd_data <= `DOU_GPIO_RST;
		end else begin
			gpio_rd_data <= gpio_s;                   // [RULE2]
		end
	end

	// Note: timing between select rise and a load request is the host's duty;
	// an early request loads whatever the data registers hold at that cycle [RULE22]

endmodule

//--- dou_host.sv
`timescale 1ns/10ps

// Host side of the serial port: one decoded word per select frame
module dou_host (
	input  wire        core_clk,
	output reg         chip_select_n,
	output reg         host_wr_valid,
	output reg  [2:0]  host_wr_chan,
	output reg  [13:0] host_wr_data
);
	// Select idles high, hardware reset included
	initial begin
		chip_select_n = 1'b1;
		host_wr_valid = 1'b0;
		host_wr_chan = 3'h0;
		host_wr_data = 14'h0000;
	end

	// Gap stretches the frame so that a slow host is covered as well
	task send(input [2:0] ch, input [13:0] dat, input integer gap);
		integer i;
		begin
			@(negedge core_clk);
			chip_select_n = 1'b0;
			host_wr_valid = 1'b1;
			host_wr_chan = ch;
			host_wr_data = dat;
			@(negedge core_clk);
			host_wr_valid = 1'b0;
			// Released lines show the inverse, never a stale copy
			host_wr_chan = ~ch;
			host_wr_data = ~dat;
			for (i = 0; i < gap; i = i + 1)
				@(negedge core_clk);
			chip_select_n = 1'b1;
			// The select rise takes three edges to commit; a new word before that
			// would overwrite the staged one, so the next frame waits
			repeat (4) @(negedge core_clk);
		end
	endtask
endmodule

//--- dou_ctrl_sva.sv
`timescale 1ns/10ps

module dou_ctrl_sva (
	input wire         core_clk,
	input wire         resetn,
	input wire         hw_reset_n,
	input wire         soft_reset,
	input wire         output_clear_n,
	input wire         latch_load_strobe_n,
	input wire         latch_load_bit,
	input wire         correction_engine_on,
	input wire         host_wr_valid,
	input wire [13:0]  host_wr_data,
	input wire         gpio_wr,
	input wire [2:0]   gpio_wr_data,
	input wire [2:0]   gpio_in,
	input wire [2:0]   gpio_out,
	input wire [2:0]   gpio_oe_n,
	input wire [2:0]   gpio_rd_data,
	input wire [13:0]  input_data,
	input wire [111:0] chan_latch,
	input wire [111:0] chan_data,
	input wire [7:0]   access_flags,
	input wire         outputs_cleared,
	input wire         serial_enable,
	input wire         sdo_oe_n,
	input wire         sync_mode,
	input wire         mode_valid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// Pin level only ever driven low; floating is done by the enable
	a_gpio_low_only: assert property (gpio_out == 3'h0) else $error("gpio drives high");
	a_gpio_take: assert property (gpio_wr && serial_enable |=> gpio_oe_n == $past(gpio_wr_data))
		else $error("gpio bits not taken");
	a_gpio_read: assert property ((serial_enable && $stable(gpio_in))[*4] |-> gpio_rd_data == gpio_in)
		else $error("gpio read not pin level");
	a_clear_sets: assert property ((!output_clear_n && mode_valid)[*6] |-> outputs_cleared)
		else $error("clear did not ground outputs");
	// Released clear with strobe high must keep the outputs grounded
	a_clear_stays: assert property ((outputs_cleared && latch_load_strobe_n && hw_reset_n && !soft_reset)[*4]
		|=> outputs_cleared) else $error("clear released without strobe low");
	a_clear_keeps: assert property ($fell(output_clear_n) |=> $stable(chan_latch) && $stable(chan_data))
		else $error("clear changed stored codes");
	a_serial_off: assert property (!hw_reset_n[*4] |-> !serial_enable && sdo_oe_n)
		else $error("serial port live in reset");
	a_input_take: assert property (host_wr_valid && serial_enable |=> input_data == $past(host_wr_data))
		else $error("input word not taken");
	a_mode_fixed: assert property ($past(mode_valid) && mode_valid |-> $stable(sync_mode))
		else $error("update mode changed");
	// Quiet strobe and no load bit: latches must not move
	a_sync_hold: assert property ((sync_mode && mode_valid && hw_reset_n && !soft_reset && !latch_load_bit
		&& latch_load_strobe_n && !correction_engine_on)[*6] |=> $stable(chan_latch)) else $error("latch moved");
	a_load_flags: assert property (latch_load_bit && sync_mode && mode_valid && !correction_engine_on
		|-> ##[1:2] access_flags == 8'h00) else $error("access flags kept after load");
endmodule

bind dou_ctrl dou_ctrl_sva chk_i (.*);

//--- dou_ctrl_tb.sv
`timescale 1ns/10ps
`include "dou_consts.vh"

module dou_ctrl_tb;
	reg          core_clk, resetn, hw_reset_n, soft_reset, output_clear_n, latch_load_strobe_n;
	reg          reset_level_select, code_format_select, single_supply, latch_load_bit, correction_engine_on;
	reg          eng_wr_valid, eng_busy, sdo_drive, gpio_wr;
	reg  [2:0]   eng_wr_chan, gpio_wr_data, gpio_in;
	reg  [13:0]  eng_wr_data;
	reg  [111:0] exp;
	wire         chip_select_n, host_wr_valid, eng_req, outputs_cleared, offset_dac_on, cal_defaults_load;
	wire         serial_enable, sdo_oe_n, sync_mode, mode_valid;
	wire [2:0]   host_wr_chan, gpio_out, gpio_oe_n, gpio_rd_data, eng_req_chan;
	wire [13:0]  host_wr_data, input_data, offset_code;
	wire [111:0] chan_latch, chan_data;
	wire [7:0]   access_flags;
	integer      err_total, compares;
	reg  [2:0]   req_chan;
	integer      req_hits;

	dou_ctrl dut (.*);
	dou_host hst (.*);

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Engine hand-off stands one cycle only; count it where it stands
	always @(negedge core_clk) begin
		if (eng_req === 1'b1) begin
			req_hits = req_hits + 1;
			req_chan = eng_req_chan;
		end
	end

	// Time-zero input values, set from the main sequence so that no race with the straps
	task init_inputs;
		begin
			{resetn, hw_reset_n, soft_reset, output_clear_n, latch_load_strobe_n} = 5'h0b;
			{reset_level_select, code_format_select, single_supply, latch_load_bit} = 4'h0;
			{correction_engine_on, eng_wr_valid, eng_busy, sdo_drive, gpio_wr} = 5'h02;
			{eng_wr_chan, gpio_wr_data, gpio_in, eng_wr_data} = 23'h0;
			err_total = 0;
			compares = 0;
			req_hits = 0;
		end
	endtask

	task cyc(input integer n);
		repeat (n) @(negedge core_clk);
	endtask

	task chk(input [111:0] got, input [111:0] want);
		begin
			compares = compares + 1;
			if (got !== want) begin
				err_total = err_total + 1;
				$display("[FAIL] %0t got %h expected %h", $time, got, want);
			end
		end
	endtask

	// Bounded wait: the port reopens a few edges after any reset
	task wait_ready;
		integer i;
		begin
			cyc(2);
			for (i = 0; i < 40 && serial_enable !== 1'b1; i = i + 1)
				cyc(1);
			chk(serial_enable, 1'b1);
		end
	endtask

	// Straps stay steady across the whole power-on
	task power_on(input s, input l, input f, input ss);
		begin
			resetn = 1'b0;
			latch_load_strobe_n = s;
			{reset_level_select, code_format_select, single_supply} = {l, f, ss};
			cyc(5);
			resetn = 1'b1;
			wait_ready;
		end
	endtask

	task presets(input [13:0] code, input s, input ss);
		begin
			chk(chan_data, {8{code}});
			chk(chan_latch, {8{code}});
			chk(input_data, 14'h0000);
			chk(gpio_oe_n, `DOU_GPIO_RST);
			chk(sync_mode, s);
			chk(offset_dac_on, !ss);
			exp = {8{code}};
		end
	endtask

	task ld_bit;
		begin
			latch_load_bit = 1'b1;
			cyc(1);
			latch_load_bit = 1'b0;
			cyc(2);
		end
	endtask

	// Writes stay staged until a load, then only flagged channels move
	task t_sync_load;
		begin
			hst.send(3'h2, 14'h1abc, 0);
			hst.send(3'h7, 14'h3fff, 6);
			cyc(8);
			chk(chan_latch, exp);
			chk(chan_data[28 +: 14], 14'h1abc);
			chk(access_flags, 8'h84);
			ld_bit;
			exp[28 +: 14] = 14'h1abc;
			exp[98 +: 14] = 14'h3fff;
			chk(chan_latch, exp);
			chk(access_flags, 8'h00);
			hst.send(3'h0, 14'h0155, 0);
			cyc(8);
			latch_load_strobe_n = 1'b0;
			cyc(2);
			latch_load_strobe_n = 1'b1;
			cyc(6);
			exp[13:0] = 14'h0155;
			chk(chan_latch, exp);
		end
	endtask

	// Strobe pulse inside clear is ignored; release needs strobe low
	task t_clear;
		begin
			output_clear_n = 1'b0;
			cyc(6);
			chk(outputs_cleared, 1'b1);
			latch_load_strobe_n = 1'b0;
			cyc(2);
			latch_load_strobe_n = 1'b1;
			cyc(4);
			output_clear_n = 1'b1;
			cyc(6);
			chk(outputs_cleared, 1'b1);
			chk(chan_latch, exp);
			latch_load_strobe_n = 1'b0;
			cyc(6);
			chk(outputs_cleared, 1'b0);
			latch_load_strobe_n = 1'b1;
			cyc(4);
		end
	endtask

	task t_gpio;
		begin
			gpio_in = 3'h2;
			gpio_wr_data = 3'h5;
			gpio_wr = 1'b1;
			cyc(1);
			gpio_wr = 1'b0;
			cyc(4);
			chk(gpio_oe_n, 3'h5);
			chk(gpio_out, 3'h0);
			chk(gpio_rd_data, 3'h2);
			soft_reset = 1'b1;
			cyc(1);
			soft_reset = 1'b0;
			wait_ready;
			chk(gpio_oe_n, 3'h7);
		end
	endtask

	// Hardware reset undoes a load and silences the port
	task t_hw_reset;
		begin
			hst.send(3'h1, 14'h2aaa, 0);
			cyc(8);
			ld_bit;
			hw_reset_n = 1'b0;
			cyc(5);
			chk(serial_enable, 1'b0);
			chk(sdo_oe_n, 1'b1);
			chk(chan_latch, {8{`DOU_CODE_MID}});
			chk(input_data, `DOU_INDATA_RST);
			chk(cal_defaults_load, 1'b1);
			chk(offset_code, `DOU_OFS_USB);
			hw_reset_n = 1'b1;
			wait_ready;
			chk(chan_latch, {8{`DOU_CODE_MID}});
			hst.send(3'h4, 14'h0777, 0);
			chk(input_data, 14'h0777);
		end
	endtask

	// Strobe tied low: select rise and engine writes go straight out
	task t_async;
		begin
			hst.send(3'h3, 14'h1234, 2);
			cyc(8);
			exp[42 +: 14] = 14'h1234;
			chk(chan_latch, exp);
			output_clear_n = 1'b0;
			cyc(6);
			output_clear_n = 1'b1;
			cyc(6);
			chk(outputs_cleared, 1'b0);
			correction_engine_on = 1'b1;
			{eng_wr_valid, eng_wr_chan, eng_wr_data} = {1'b1, 3'h5, 14'h0f0f};
			cyc(1);
			{eng_wr_valid, eng_wr_chan, eng_wr_data} = {1'b0, 3'h2, 14'h30f0};
			cyc(2);
			exp[70 +: 14] = 14'h0f0f;
			chk(chan_latch, exp);
		end
	endtask

	// Engine on in sync mode: the load waits until the engine goes quiet
	task t_sync_engine;
		begin
			exp = {8{`DOU_CODE_MID}};
			correction_engine_on = 1'b1;
			eng_busy = 1'b1;
			hst.send(3'h5, 14'h0123, 0);
			chk(req_hits, 1);
			chk(req_chan, 3'h5);
			{eng_wr_valid, eng_wr_chan, eng_wr_data} = {1'b1, 3'h5, 14'h0321};
			cyc(1);
			{eng_wr_valid, eng_wr_chan, eng_wr_data} = {1'b0, 3'h2, 14'h3cde};
			ld_bit;
			chk(chan_latch, exp);
			chk(access_flags, 8'h30);
			eng_busy = 1'b0;
			cyc(2);
			exp[56 +: 14] = 14'h0777;
			exp[70 +: 14] = 14'h0321;
			chk(chan_latch, exp);
			chk(access_flags, 8'h00);
			correction_engine_on = 1'b0;
		end
	endtask

	task stop_test;
		begin
			$display("compares %0d mismatches %0d", compares, err_total);
			if (err_total == 0 && compares > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	// Main sequence: synchronous part, then a second power-on in asynchronous mode
	initial begin
		init_inputs;
		power_on(1'b1, 1'b1, 1'b0, 1'b0);
		presets(`DOU_CODE_MID, 1'b1, 1'b0);
		t_sync_load;
		t_clear;
		t_gpio;
		t_hw_reset;
		t_sync_engine;
		power_on(1'b0, 1'b1, 1'b1, 1'b1);
		presets(`DOU_CODE_ZERO, 1'b0, 1'b1);
		t_async;
		stop_test;
	end

	// Watchdog well beyond the few hundred cycles the run needs
	initial begin
		#100000;
		err_total = err_total + 1;
		stop_test;
	end
endmodule
